// File: shared/dbp_map.svh
// Offsets, field positions, reset values and timing counts of the dual bridge controller.
`ifndef DBP_MAP_SVH
`define DBP_MAP_SVH
`define DBP_SEL_HI      15
`define DBP_SEL_LO      14
`define DBP_DATA_HI     13
`define DBP_WORD_B1     2'h0
`define DBP_WORD_B2     2'h1
`define DBP_WORD_MODE   2'h2
`define DBP_RST_TIMING  16'h0040
`define DBP_RST_OTHER   16'h0000
`define DBP_BLANK_LO    0
`define DBP_OFF_LO      2
`define DBP_FAST_LO     7
`define DBP_RECT_BIT    11
`define DBP_B2_INT_BIT  0
`define DBP_B1_INT_BIT  7
`define DBP_MODE_STRIDE 7
`define DBP_CLK_NS      25
`define DBP_OSC_NS      250
`define DBP_OSC_DIV     (`DBP_OSC_NS / `DBP_CLK_NS)
`define DBP_CROSS_NS    100
`define DBP_CROSS_CYC   ((`DBP_CROSS_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_BLANK_0     5'h04
`define DBP_BLANK_1     5'h06
`define DBP_BLANK_2     5'h0C
`define DBP_BLANK_3     5'h18
`define DBP_SYNC_RST    11'h103
`endif

// File: shared/dbp_pkg.sv
// Types shared by the dual bridge controller.
package dbp_pkg;
	typedef struct packed {
		logic [1:0] blank;
		logic [4:0] off_n;
		logic [3:0] fast_n;
		logic       rect_passive;
		logic       int_slow;
		logic       ext_slow;
		logic       phase;
	} dbp_cfg_t;

	typedef struct packed {
		logic leg_first_hi;
		logic leg_first_lo;
		logic leg_second_hi;
		logic leg_second_lo;
	} dbp_gates_t;

	typedef enum logic [2:0] {
		DBP_ON    = 3'b001,
		DBP_CROSS = 3'b010,
		DBP_DECAY = 3'b100
	} dbp_state_t;
endpackage

// File: verilog/dbp_top.sv
// Serial configuration store and PWM timing for two motor full bridges.
`timescale 1ns/1ps
`include "dbp_map.svh"

module dbp_top (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	input  wire logic               serial_clk,
	input  wire logic               serial_data,
	input  wire logic               load_strobe,
	input  wire logic               standby_request_n,
	input  wire logic               first_bridge_chop_input,
	input  wire logic               second_bridge_chop_input,
	input  wire logic [1:0]         sense_trip,
	input  wire logic [1:0]         zero_current,
	input  wire logic [1:0]         reverse_trip,
	input  wire logic               overcurrent,
	output dbp_pkg::dbp_gates_t     first_bridge_gates,
	output dbp_pkg::dbp_gates_t     second_bridge_gates,
	output logic [1:0]              blanking,
	output logic                    standby_active,
	output logic                    fault_latched
);

	logic [15:0]         shift_reg;
	logic [10:0]         pin_raw;
	logic [10:0]         sync_a_reg;
	logic [10:0]         sync_b_reg;
	logic                strobe_d_reg;
	logic                load_pulse;
	logic                stby_n;
	logic                ocp;
	logic [15:0]         cfg_word_reg [4];
	logic                fault_reg;
	logic                standby_reg;
	logic                run;
	logic [3:0]          osc_cnt_reg;
	logic                tick_reg;
	dbp_pkg::dbp_gates_t gate_reg [2];
	logic [1:0]          blank_on_reg;

	// Off-time and fast-decay lengths share one form: (1+N)*8-1 ticks.
	function automatic logic [7:0] span_len(input logic [4:0] n);
		span_len = {n, 3'h7};
	endfunction

	function automatic logic [4:0] blank_len(input logic [1:0] code);
		case (code)
			2'h0:    blank_len = `DBP_BLANK_0;
			2'h1:    blank_len = `DBP_BLANK_1;
			2'h2:    blank_len = `DBP_BLANK_2;
			default: blank_len = `DBP_BLANK_3;
		endcase
	endfunction

	function automatic dbp_pkg::dbp_cfg_t cfg_of(
		input logic [15:0] timing,
		input logic [15:0] mode,
		input int          mode_lo
	);
		dbp_pkg::dbp_cfg_t c;
		c.blank        = timing[`DBP_BLANK_LO +: 2];
		c.off_n        = timing[`DBP_OFF_LO +: 5];
		c.fast_n       = timing[`DBP_FAST_LO +: 4];
		c.rect_passive = timing[`DBP_RECT_BIT];
		c.int_slow     = mode[mode_lo];
		c.ext_slow     = mode[mode_lo + 1];
		c.phase        = mode[mode_lo + 2];
		cfg_of         = c;
	endfunction

	// Link side: the host clock shifts data only while strobe is low.
	always_ff @(posedge serial_clk) begin
		if (!load_strobe) begin
			shift_reg <= {shift_reg[14:0], serial_data};
		end
	end

	assign pin_raw = {overcurrent, standby_request_n, load_strobe, reverse_trip,
		zero_current, sense_trip, second_bridge_chop_input, first_bridge_chop_input};

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync_a_reg <= `DBP_SYNC_RST;
			sync_b_reg <= `DBP_SYNC_RST;
		end else begin
			sync_a_reg <= pin_raw;
			sync_b_reg <= sync_a_reg;
		end
	end

	assign stby_n = sync_b_reg[9];
	assign ocp    = sync_b_reg[10];

	// The shift register is quiet while strobe is high, so it is read
	// only once the strobe rise has crossed into this domain.
	// Strobe resets to its idle high level so that no false load follows reset.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			strobe_d_reg <= 1'b1;
		end else begin
			strobe_d_reg <= sync_b_reg[8];
		end
	end

	assign load_pulse = sync_b_reg[8] & ~strobe_d_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_b || !stby_n || ocp || fault_reg) begin
			cfg_word_reg[0] <= `DBP_RST_TIMING;
			cfg_word_reg[1] <= `DBP_RST_TIMING;
			cfg_word_reg[2] <= `DBP_RST_OTHER;
			cfg_word_reg[3] <= `DBP_RST_OTHER;
		end else if (load_pulse) begin
			// Select bits address the word; only data bits are stored.
			cfg_word_reg[shift_reg[`DBP_SEL_HI:`DBP_SEL_LO]] <=
				{2'h0, shift_reg[`DBP_DATA_HI:0]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fault_reg <= 1'b0;
		end else if (ocp) begin
			fault_reg <= 1'b1;
		end else if (!stby_n) begin
			fault_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			standby_reg <= 1'b1;
		end else begin
			standby_reg <= ~stby_n;
		end
	end

	assign run = stby_n & ~fault_reg;

	// Internal oscillator period derived from the system clock.
	always_ff @(posedge clk_sys) begin
		if (!rst_b || osc_cnt_reg == 4'(`DBP_OSC_DIV - 1)) begin
			osc_cnt_reg <= 4'h0;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (osc_cnt_reg == 4'(`DBP_OSC_DIV - 1));
		end
	end

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bridge
			dbp_pkg::dbp_cfg_t  cfg;
			dbp_pkg::dbp_state_t state_reg;
			logic [7:0] off_len;
			logic [7:0] fast_len;
			logic [7:0] tmr_reg;
			logic [7:0] elapsed_reg;
			logic [4:0] blank_reg;
			logic [2:0] cross_reg;
			logic       ext_reg;
			logic       phase_d_reg;
			logic       rect_off_reg;
			logic       chop_n;
			logic       trip;
			logic       phase_chg;
			logic       fast_now;
			dbp_pkg::dbp_gates_t drive;

			assign cfg = cfg_of(cfg_word_reg[b], cfg_word_reg[2],
				(b == 0) ? `DBP_B1_INT_BIT : `DBP_B2_INT_BIT);
			assign off_len   = span_len(cfg.off_n);
			assign fast_len  = span_len({1'b0, cfg.fast_n});
			assign chop_n    = sync_b_reg[b];
			assign trip      = sync_b_reg[2 + b];
			assign phase_chg = cfg.phase != phase_d_reg;

			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					phase_d_reg <= 1'b0;
				end else begin
					phase_d_reg <= cfg.phase;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b || !run) begin
					state_reg   <= dbp_pkg::DBP_CROSS;
					ext_reg     <= 1'b1;
					tmr_reg     <= 8'h00;
					elapsed_reg <= 8'h00;
					cross_reg   <= 3'h0;
					blank_reg   <= 5'h00;
				end else if (!chop_n && !ext_reg) begin
					state_reg   <= dbp_pkg::DBP_CROSS;
					ext_reg     <= 1'b1;
					cross_reg   <= 3'h0;
					elapsed_reg <= 8'h00;
					blank_reg   <= 5'h00;
				end else if (phase_chg) begin
					state_reg   <= dbp_pkg::DBP_CROSS;
					ext_reg     <= ~chop_n;
					tmr_reg     <= off_len;
					cross_reg   <= 3'h0;
					elapsed_reg <= 8'h00;
					blank_reg   <= 5'h00;
				end else begin
					case (state_reg)
						dbp_pkg::DBP_ON: begin
							if (blank_reg != 5'h00) begin
								if (tick_reg) begin
									blank_reg <= blank_reg - 5'h01;
								end
							end else if (trip) begin
								state_reg   <= dbp_pkg::DBP_CROSS;
								ext_reg     <= 1'b0;
								tmr_reg     <= off_len;
								cross_reg   <= 3'h0;
								elapsed_reg <= 8'h00;
							end
						end
						dbp_pkg::DBP_CROSS: begin
							if (cross_reg == 3'(`DBP_CROSS_CYC - 1)) begin
								state_reg <= dbp_pkg::DBP_DECAY;
							end else begin
								cross_reg <= cross_reg + 3'h1;
							end
						end
						dbp_pkg::DBP_DECAY: begin
							if (ext_reg) begin
								if (chop_n) begin
									state_reg <= dbp_pkg::DBP_ON;
									ext_reg   <= 1'b0;
									blank_reg <= blank_len(cfg.blank);
								end
							end else if (tick_reg) begin
								if (tmr_reg == 8'h00) begin
									state_reg <= dbp_pkg::DBP_ON;
									blank_reg <= blank_len(cfg.blank);
								end else begin
									tmr_reg <= tmr_reg - 8'h01;
								end
								if (elapsed_reg != 8'hFF) begin
									elapsed_reg <= elapsed_reg + 8'h01;
								end
							end
						end
						default: begin
							state_reg <= dbp_pkg::DBP_CROSS;
							ext_reg   <= 1'b1;
						end
					endcase
				end
			end

			// A fast-decay span longer than the off-time never runs out.
			assign fast_now = ext_reg ? ~cfg.ext_slow :
				(~cfg.int_slow && elapsed_reg < fast_len);

			always_ff @(posedge clk_sys) begin
				if (!rst_b || state_reg != dbp_pkg::DBP_DECAY) begin
					rect_off_reg <= 1'b0;
				end else if (cfg.rect_passive ? sync_b_reg[6 + b] : sync_b_reg[4 + b]) begin
					rect_off_reg <= 1'b1;
				end
			end

			always_comb begin
				drive = 4'h0;
				case (state_reg)
					dbp_pkg::DBP_ON: begin
						drive = cfg.phase ? 4'b1001 : 4'b0110;
					end
					dbp_pkg::DBP_DECAY: begin
						if (rect_off_reg) begin
							drive = 4'h0;
						end else if (fast_now) begin
							drive = cfg.phase ? 4'b0110 : 4'b1001;
						end else begin
							drive = 4'b0101;
						end
					end
					default: begin
						drive = 4'h0;
					end
				endcase
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b || !run || ocp) begin
					gate_reg[b]     <= 4'h0;
					blank_on_reg[b] <= 1'b0;
				end else begin
					gate_reg[b]     <= drive;
					blank_on_reg[b] <= state_reg == dbp_pkg::DBP_ON && blank_reg != 5'h00;
				end
			end
		end
	endgenerate

	// The serial pins are inputs only; no output of this block faces the host.
	assign first_bridge_gates  = gate_reg[0];
	assign second_bridge_gates = gate_reg[1];
	assign blanking            = blank_on_reg;
	assign standby_active      = standby_reg;
	assign fault_latched       = fault_reg;

endmodule

// File: tb/dbp_host.sv
// Host model that writes configuration words over the strobed serial port.
`timescale 1ns/1ps
module dbp_host (
	input  wire logic clk_sys,
	output logic      serial_clk,
	output logic      serial_data,
	output logic      load_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b1;
	end

	// The link clock runs only inside a frame; data is inverted afterwards so stale sampling shows.
	task automatic send(input logic [15:0] word);
		@(posedge clk_sys);
		load_strobe <= 1'b0;
		#3.1;
		for (int i = 15; i >= 0; i--) begin
			serial_data = word[i];
			#7.5 serial_clk = 1'b1;
			#7.5 serial_clk = 1'b0;
		end
		#4.0 load_strobe = 1'b1;
		serial_data = ~word[0];
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

// File: tb/dbp_top_props.sv
// Checker for the gate, blanking, standby and fault outputs.
`timescale 1ns/1ps
module dbp_top_props (
	input wire logic                clk_sys,
	input wire logic                rst_b,
	input wire logic                serial_clk,
	input wire logic                serial_data,
	input wire logic                load_strobe,
	input wire logic                standby_request_n,
	input wire logic                first_bridge_chop_input,
	input wire logic                second_bridge_chop_input,
	input wire logic [1:0]          sense_trip,
	input wire logic [1:0]          zero_current,
	input wire logic [1:0]          reverse_trip,
	input wire logic                overcurrent,
	input wire dbp_pkg::dbp_gates_t first_bridge_gates,
	input wire dbp_pkg::dbp_gates_t second_bridge_gates,
	input wire logic [1:0]          blanking,
	input wire logic                standby_active,
	input wire logic                fault_latched
);
	logic [3:0] g1;
	logic [3:0] g2;
	logic [3:0] g1_q_reg;
	logic       on_drive_reg;
	assign g1 = first_bridge_gates;
	assign g2 = second_bridge_gates;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Marks source drive of bridge one: set by blanking, cleared when the pattern changes.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			g1_q_reg     <= 4'h0;
			on_drive_reg <= 1'b0;
		end else begin
			g1_q_reg <= g1;
			if (blanking[0]) begin
				on_drive_reg <= 1'b1;
			end else if (g1 != g1_q_reg) begin
				on_drive_reg <= 1'b0;
			end
		end
	end

	reset_state_a: assert property (disable iff (1'b0)
		!rst_b [*2] |-> standby_active && !fault_latched && g1 == 4'h0 && g2 == 4'h0)
		else $error("Outputs wrong during reset.");
	standby_gates_a: assert property (
		!standby_request_n [*4] |-> standby_active && g1 == 4'h0 && g2 == 4'h0)
		else $error("Gates not off in standby.");
	fault_gates_a: assert property (fault_latched |-> g1 == 4'h0 && g2 == 4'h0)
		else $error("Gates driven while fault latched.");
	fault_hold_a: assert property (
		fault_latched && !standby_active |=> fault_latched || standby_active)
		else $error("Fault released without standby.");
	fault_set_a: assert property (
		overcurrent && !standby_active && standby_request_n |-> ##[1:5] fault_latched)
		else $error("Overcurrent not latched.");
	blank_on_a: assert property (
		$rose(blanking[0]) |-> ##[0:1] (g1 == 4'h9 || g1 == 4'h6))
		else $error("Blanking started without source drive.");
	cross_gap_a: assert property (
		$past(g1) inside {4'h9, 4'h6} && g1 == 4'h0 |-> g1 == 4'h0 [*4])
		else $error("Crossover gap missing.");
	gate_codes_a: assert property (
		g1 inside {4'h0, 4'h5, 4'h6, 4'h9} && g2 inside {4'h0, 4'h5, 4'h6, 4'h9})
		else $error("Illegal gate pattern.");
	trip_off_a: assert property (
		sense_trip[0] && !blanking[0] && on_drive_reg && g1 inside {4'h9, 4'h6}
		|-> ##[1:6] g1 == 4'h0)
		else $error("Sense trip did not end drive.");
	chop_off_a: assert property (
		$fell(first_bridge_chop_input) && g1 inside {4'h9, 4'h6} |-> ##[1:6] g1 == 4'h0)
		else $error("Chop did not end drive.");

	cover property ($rose(fault_latched));
	cover property (g1 == 4'h5);
	cover property ($rose(blanking[0]));
endmodule

bind dbp_top dbp_top_props u_dbp_top_props (.clk_sys(clk_sys), .rst_b(rst_b),
	.serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe),
	.standby_request_n(standby_request_n), .first_bridge_chop_input(first_bridge_chop_input),
	.second_bridge_chop_input(second_bridge_chop_input), .sense_trip(sense_trip),
	.zero_current(zero_current), .reverse_trip(reverse_trip), .overcurrent(overcurrent),
	.first_bridge_gates(first_bridge_gates), .second_bridge_gates(second_bridge_gates),
	.blanking(blanking), .standby_active(standby_active), .fault_latched(fault_latched));

// File: tb/dbp_top_bench.sv
// Self-checking bench for the dual bridge controller.
`timescale 1ns/1ps
module dbp_top_bench;
	logic                clk_sys = 1'b0;
	logic                rst_b = 1'b0;
	logic                standby_request_n = 1'b1;
	logic                first_bridge_chop_input = 1'b1;
	logic                second_bridge_chop_input = 1'b1;
	logic [1:0]          reverse_trip = 2'h0;
	logic [1:0]          sense_trip = 2'h0;
	logic [1:0]          zero_current = 2'h0;
	logic                overcurrent = 1'b0;
	logic                serial_clk;
	logic                serial_data;
	logic                load_strobe;
	dbp_pkg::dbp_gates_t first_bridge_gates;
	dbp_pkg::dbp_gates_t second_bridge_gates;
	logic [1:0]          blanking;
	logic                standby_active;
	logic                fault_latched;
	int                  n_fail = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	int                  n;

	always #12.5 clk_sys = ~clk_sys;

	dbp_host u_host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_data(serial_data),
		.load_strobe(load_strobe));

	dbp_top u_dbp_top (.clk_sys(clk_sys), .rst_b(rst_b), .serial_clk(serial_clk),
		.serial_data(serial_data), .load_strobe(load_strobe),
		.standby_request_n(standby_request_n), .first_bridge_chop_input(first_bridge_chop_input),
		.second_bridge_chop_input(second_bridge_chop_input), .sense_trip(sense_trip),
		.zero_current(zero_current), .reverse_trip(reverse_trip), .overcurrent(overcurrent),
		.first_bridge_gates(first_bridge_gates),
		.second_bridge_gates(second_bridge_gates), .blanking(blanking),
		.standby_active(standby_active), .fault_latched(fault_latched));

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 12000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cy(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic wait_g1(input logic [3:0] g, output int cnt);
		cnt = 0;
		while (first_bridge_gates !== g && cnt < 2000) begin
			cy(1);
			cnt++;
		end
	endtask

	task automatic s_phase();
		u_host.send(16'h0004);
		u_host.send(16'h8200);
		wait_g1(4'h9, n);
		check(first_bridge_gates, 4'h9);
		check({3'h0, n > 120 && n < 180}, 4'h1);
		u_host.send(16'hFFFF);
		cy(20);
		check(first_bridge_gates, 4'h9);
		check(second_bridge_gates, 4'h6);
	endtask

	task automatic s_trip(input logic [15:0] w, input logic [3:0] late);
		u_host.send(w);
		cy(60);
		sense_trip <= 2'h1;
		cy(3);
		sense_trip <= 2'h0;
		cy(9);
		check(first_bridge_gates, 4'h6);
		cy(98);
		check(first_bridge_gates, late);
		wait_g1(4'h9, n);
		check({3'h0, blanking[0]}, 4'h1);
		sense_trip <= 2'h1;
		cy(2);
		sense_trip <= 2'h0;
		cy(8);
		check(first_bridge_gates, 4'h9);
		cy(22);
		check({3'h0, blanking[0]}, 4'h1);
		cy(23);
		check({3'h0, blanking[0]}, 4'h0);
	endtask

	task automatic s_chop(input logic [15:0] w, input logic [3:0] decay);
		u_host.send(w);
		first_bridge_chop_input <= 1'b0;
		second_bridge_chop_input <= 1'b0;
		cy(12);
		check(first_bridge_gates, decay);
		check(second_bridge_gates, 4'h9);
		zero_current <= 2'h1;
		cy(6);
		check(first_bridge_gates, 4'h0);
		zero_current <= 2'h0;
		first_bridge_chop_input <= 1'b1;
		second_bridge_chop_input <= 1'b1;
		wait_g1(4'h9, n);
		check(first_bridge_gates, 4'h9);
		cy(60);
		check(second_bridge_gates, 4'h6);
	endtask

	task automatic s_passive();
		u_host.send(16'h0804);
		first_bridge_chop_input <= 1'b0;
		cy(12);
		check(first_bridge_gates, 4'h5);
		zero_current <= 2'h1;
		cy(6);
		check(first_bridge_gates, 4'h5);
		zero_current <= 2'h0;
		reverse_trip <= 2'h1;
		cy(6);
		check(first_bridge_gates, 4'h0);
		reverse_trip <= 2'h0;
		first_bridge_chop_input <= 1'b1;
		wait_g1(4'h9, n);
		check(first_bridge_gates, 4'h9);
	endtask

	task automatic s_fault();
		overcurrent <= 1'b1;
		cy(8);
		overcurrent <= 1'b0;
		check({fault_latched, first_bridge_gates === 4'h0, 2'h0}, 4'hC);
		u_host.send(16'h0004);
		check({3'h0, fault_latched}, 4'h1);
		standby_request_n <= 1'b0;
		cy(8);
		check({standby_active, fault_latched, 2'h0}, 4'h8);
		standby_request_n <= 1'b1;
		cy(6);
		wait_g1(4'h6, n);
		check(first_bridge_gates, 4'h6);
		check(second_bridge_gates, 4'h6);
		cy(60);
		sense_trip <= 2'h3;
		cy(3);
		sense_trip <= 2'h0;
		cy(12);
		wait_g1(4'h6, n);
		check({3'h0, n > 1290 && n < 1400}, 4'h1);
	endtask

	initial begin
		cy(20);
		rst_b <= 1'b1;
		cy(1600);
		check(first_bridge_gates, 4'h6);
		check({second_bridge_gates, standby_active}, 5'h0C);
		s_phase();
		s_trip(16'h0004, 4'h5);
		s_trip(16'h0784, 4'h6);
		s_chop(16'h8200, 4'h6);
		s_chop(16'h8300, 4'h5);
		s_passive();
		s_fault();
		print_verdict();
	end
endmodule
